// >>> core/otp_prog_ctrl.sv
// program and verify mode control for the otp code memory
`timescale 1ns/1ps
module otp_prog_ctrl (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // mode entry and control pins
  input  wire logic       serial_code_in,
  input  wire logic       program_strobe_n,
  input  wire logic       vpp_high,
  input  wire logic       address_byte_select,
  // address and data ports
  input  wire logic [7:0] port3_in,
  input  wire logic [7:0] port1_in,
  output logic      [7:0] port1_out,
  output logic      [7:0] port1_oe,
  // status
  output logic            mode_valid
);

  // ***************************************************
  // input synchronisers
  // ***************************************************
  logic [19:0] pin_meta_reg;
  logic [19:0] pin_sync_reg;
  logic        ser_s;
  logic        strobe_n_s;
  logic        vpp_s;
  logic        address_byte_select_s;
  logic [7:0]  p3_s;
  logic [7:0]  p1_s;

  // two flops on every pin before use
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= 20'h00002; // strobe idles high, vpp, select and serial low
      pin_sync_reg <= 20'h00002;
    end
    else
    begin
      pin_meta_reg <= {port1_in, port3_in, address_byte_select, vpp_high,
                       program_strobe_n, serial_code_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign {p1_s, p3_s, address_byte_select_s, vpp_s, strobe_n_s, ser_s} = pin_sync_reg;

  // ***************************************************
  // serial mode entry
  // ***************************************************
  otp_prog_pkg::entry_t ent_reg;
  otp_prog_pkg::mode_t  mode_reg;
  logic [9:0]           shift_reg;
  logic [4:0]           arm_cnt_reg;
  logic [3:0]           bit_cnt_reg;
  logic [9:0]           code_next;

  assign code_next = {ser_s, shift_reg[9:1]};

  // high for 24 clocks arms; then one bit per clock, lsb first
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ent_reg     <= otp_prog_pkg::ENT_IDLE;
      arm_cnt_reg <= 5'h00;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 10'h000;
    end
    else
    begin
      if (!ser_s)
        arm_cnt_reg <= 5'h00;
      else if (arm_cnt_reg != otp_prog_pkg::ARM_CYCLES)
        arm_cnt_reg <= arm_cnt_reg + 5'h01;
      unique case (ent_reg)
        otp_prog_pkg::ENT_IDLE, otp_prog_pkg::ENT_DONE:
        begin
          if (arm_cnt_reg == otp_prog_pkg::ARM_CYCLES)
            ent_reg <= otp_prog_pkg::ENT_ARMED;
        end
        otp_prog_pkg::ENT_ARMED:
        begin
          // first low after the arming level is bit 0
          if (!ser_s)
          begin
            shift_reg   <= code_next;
            bit_cnt_reg <= 4'h1;
            ent_reg     <= otp_prog_pkg::ENT_SHIFT;
          end
        end
        otp_prog_pkg::ENT_SHIFT:
        begin
          shift_reg   <= code_next;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == otp_prog_pkg::LAST_BIT)
            ent_reg <= otp_prog_pkg::ENT_DONE;
        end
      endcase
    end
  end

  // decode the finished code into a mode
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= otp_prog_pkg::MODE_NONE;
    else if (ent_reg == otp_prog_pkg::ENT_ARMED)
      mode_reg <= otp_prog_pkg::MODE_NONE;
    else if (ent_reg == otp_prog_pkg::ENT_SHIFT &&
             bit_cnt_reg == otp_prog_pkg::LAST_BIT)
    begin
      unique case (code_next)
        otp_prog_pkg::CODE_USER: mode_reg <= otp_prog_pkg::MODE_USER;
        otp_prog_pkg::CODE_KEY:  mode_reg <= otp_prog_pkg::MODE_KEY;
        otp_prog_pkg::CODE_SEC1: mode_reg <= otp_prog_pkg::MODE_SEC1;
        otp_prog_pkg::CODE_SEC2: mode_reg <= otp_prog_pkg::MODE_SEC2;
        default:                 mode_reg <= otp_prog_pkg::MODE_NONE;
      endcase
    end
  end

  assign mode_valid = (mode_reg != otp_prog_pkg::MODE_NONE);

  // ***************************************************
  // address multiplexing
  // ***************************************************
  logic [10:0] addr_reg;

  // high bits follow port 3 while select is high, low byte otherwise
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      addr_reg <= 11'h000;
    else if (address_byte_select_s)
      addr_reg[10:8] <= p3_s[otp_prog_pkg::ADDR_HI_W-1:0];
    else
      addr_reg[7:0] <= p3_s;
  end

  // ***************************************************
  // programming pulse counter
  // ***************************************************
  logic       strobe_d_reg;
  logic [4:0] pulse_cnt_reg;
  logic       pulse_end;
  logic       prog_fire;

  assign pulse_end = strobe_n_s && !strobe_d_reg;
  assign prog_fire = vpp_s && pulse_end &&
                     (pulse_cnt_reg == otp_prog_pkg::PULSE_COUNT);

  // count low pulses while vpp is high; write on the return of the last
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_d_reg  <= 1'b1;
      pulse_cnt_reg <= 5'h00;
    end
    else
    begin
      strobe_d_reg <= strobe_n_s;
      if (!vpp_s)
        pulse_cnt_reg <= 5'h00;
      else if (!strobe_n_s && strobe_d_reg &&
               pulse_cnt_reg != otp_prog_pkg::PULSE_COUNT)
        pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
    end
  end

  // ***************************************************
  // storage
  // ***************************************************
  logic       sec1;
  logic       sec2;
  logic [7:0] user_q;
  logic [7:0] key_q;
  logic       wr_user;
  logic       wr_key;
  logic       wr_sec1;
  logic       wr_sec2;

  // array writes blocked once security bit 1 is set
  assign wr_user = prog_fire && mode_reg == otp_prog_pkg::MODE_USER && !sec1;
  assign wr_key  = prog_fire && mode_reg == otp_prog_pkg::MODE_KEY && !sec1;
  // security writes take no address or data
  assign wr_sec1 = prog_fire && mode_reg == otp_prog_pkg::MODE_SEC1;
  assign wr_sec2 = prog_fire && mode_reg == otp_prog_pkg::MODE_SEC2;

  otp_array u_array (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .rd_addr  (addr_reg),
    .user_q   (user_q),
    .key_q    (key_q),
    .wr_user  (wr_user),
    .wr_key   (wr_key),
    .wr_sec1  (wr_sec1),
    .wr_sec2  (wr_sec2),
    .wr_addr  (addr_reg),
    .wr_data  (p1_s),
    .sec1_reg (sec1),
    .sec2_reg (sec2)
  );

  // ***************************************************
  // verify output on port 1
  // ***************************************************
  logic       verify_on;
  logic [7:0] out_next;
  logic [7:0] oe_next;

  assign verify_on = !vpp_s && strobe_n_s;

  // choose verify data and which port 1 bits are driven
  always_comb
  begin
    out_next = 8'h00;
    oe_next  = 8'h00;
    if (verify_on)
    begin
      unique case (mode_reg)
        otp_prog_pkg::MODE_USER:
        begin
          if (!sec2)
          begin
            out_next = ~(user_q ^ key_q);
            oe_next  = 8'hff;
          end
        end
        otp_prog_pkg::MODE_KEY:
        begin
          if (!sec1 && !sec2)
          begin
            out_next = key_q;
            oe_next  = 8'hff;
          end
        end
        otp_prog_pkg::MODE_SEC1:
        begin
          out_next[otp_prog_pkg::SEC1_BIT] = sec1;
          out_next[otp_prog_pkg::SEC2_BIT] = sec2;
          oe_next  = otp_prog_pkg::SEC_OE_MASK;
        end
        default:
        begin
          out_next = 8'h00;
          oe_next  = 8'h00;
        end
      endcase
    end
  end

  // registered port 1, a few clocks after address or vpp change
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port1_out <= 8'h00;
      port1_oe  <= 8'h00;
    end
    else
    begin
      port1_out <= out_next;
      port1_oe  <= oe_next;
    end
  end

endmodule : otp_prog_ctrl

// >>> core/otp_prog_pkg.sv
// constants for the otp program and verify mode control
package otp_prog_pkg;
  // ***************************************************
  // serial mode codes
  // ***************************************************
  localparam int           CODE_W        = 10;
  localparam logic [9:0]   CODE_USER     = 10'h296;
  localparam logic [9:0]   CODE_KEY      = 10'h292;
  localparam logic [9:0]   CODE_SEC1     = 10'h29a;
  localparam logic [9:0]   CODE_SEC2     = 10'h298;
  // ***************************************************
  // array geometry and erased state
  // ***************************************************
  localparam int           ADDR_W        = 11;
  localparam int           ADDR_HI_W     = 3;
  localparam int           USER_DEPTH    = 2048;
  localparam int           KEY_DEPTH     = 16;
  localparam int           KEY_AW        = 4;
  localparam logic [7:0]   ERASED_BYTE   = 8'hff;
  // ***************************************************
  // readback positions on port 1
  // ***************************************************
  localparam int           SEC1_BIT      = 7;
  localparam int           SEC2_BIT      = 6;
  localparam logic [7:0]   SEC_OE_MASK   = 8'hc0;
  // ***************************************************
  // timing in oscillator periods, pulse and bit counts
  // ***************************************************
  localparam int           ARM_CLCL      = 24;
  localparam logic [4:0]   ARM_CYCLES    = 5'(ARM_CLCL);
  localparam int           PULSE_TOTAL   = 25;
  localparam logic [4:0]   PULSE_COUNT   = 5'(PULSE_TOTAL);
  localparam logic [3:0]   LAST_BIT      = 4'(CODE_W - 1);

  // decoded mode from the serial code
  typedef enum logic [4:0] {
    MODE_NONE = 5'b00001,
    MODE_USER = 5'b00010,
    MODE_KEY  = 5'b00100,
    MODE_SEC1 = 5'b01000,
    MODE_SEC2 = 5'b10000
  } mode_t;

  // serial entry states
  typedef enum logic [3:0] {
    ENT_IDLE  = 4'b0001,
    ENT_ARMED = 4'b0010,
    ENT_SHIFT = 4'b0100,
    ENT_DONE  = 4'b1000
  } entry_t;
endpackage : otp_prog_pkg

// >>> core/otp_array.sv
// one-time-programmable user, key and security storage
`timescale 1ns/1ps
module otp_array (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // read side
  input  wire logic [10:0] rd_addr,
  output logic      [7:0]  user_q,
  output logic      [7:0]  key_q,
  // write side
  input  wire logic        wr_user,
  input  wire logic        wr_key,
  input  wire logic        wr_sec1,
  input  wire logic        wr_sec2,
  input  wire logic [10:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  // security state
  output logic             sec1_reg,
  output logic             sec2_reg
);

  logic [7:0] user_mem [otp_prog_pkg::USER_DEPTH];
  logic [7:0] key_mem  [otp_prog_pkg::KEY_DEPTH];

  // user array: erased to ones, programming only clears bits
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < otp_prog_pkg::USER_DEPTH; i++)
        user_mem[i] <= otp_prog_pkg::ERASED_BYTE;
    end
    else if (wr_user)
      user_mem[wr_addr] <= user_mem[wr_addr] & wr_data;
  end

  // key array: same erased state and write law
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < otp_prog_pkg::KEY_DEPTH; i++)
        key_mem[i] <= otp_prog_pkg::ERASED_BYTE;
    end
    else if (wr_key)
      key_mem[wr_addr[otp_prog_pkg::KEY_AW-1:0]] <=
        key_mem[wr_addr[otp_prog_pkg::KEY_AW-1:0]] & wr_data;
  end

  // security bits, sticky once programmed
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec1_reg <= 1'b0;
      sec2_reg <= 1'b0;
    end
    else
    begin
      if (wr_sec1)
        sec1_reg <= 1'b1;
      if (wr_sec2)
        sec2_reg <= 1'b1;
    end
  end

  // registered reads
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      user_q <= otp_prog_pkg::ERASED_BYTE;
      key_q  <= otp_prog_pkg::ERASED_BYTE;
    end
    else
    begin
      user_q <= user_mem[rd_addr];
      key_q  <= key_mem[rd_addr[otp_prog_pkg::KEY_AW-1:0]];
    end
  end

endmodule : otp_array

// >>> tb/otp_prog_ctrl_properties.sv
// checker for the otp program and verify control pins
`timescale 1ns/1ps
module otp_prog_ctrl_properties (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // control pins
  input wire logic       serial_code_in,
  input wire logic       program_strobe_n,
  input wire logic       vpp_high,
  input wire logic       address_byte_select,
  // ports
  input wire logic [7:0] port3_in,
  input wire logic [7:0] port1_in,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  input wire logic       mode_valid
);
  // ****
  // helper state
  // ****
  default clocking dck @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [19:0] pins_w;
  logic [5:0]  quiet_reg;
  logic        sec1_seen_reg;
  logic        sec2_seen_reg;
  assign pins_w = {serial_code_in, program_strobe_n, vpp_high, address_byte_select,
                   port3_in, port1_in};
  // cycles since any pin moved
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      quiet_reg <= 6'h00;
    else if (!$stable(pins_w))
      quiet_reg <= 6'h00;
    else if (quiet_reg != 6'h3f)
      quiet_reg <= quiet_reg + 6'h01;
  // security bits once seen set in readback
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      {sec1_seen_reg, sec2_seen_reg} <= 2'b00;
    else if (port1_oe == 8'hc0)
      {sec1_seen_reg, sec2_seen_reg} <= {sec1_seen_reg, sec2_seen_reg} | port1_out[7:6];
  // ****
  // properties
  // ****
  AST_OE_SHAPE: assert property (port1_oe inside {8'h00, 8'hc0, 8'hff})
    else $error("odd drive enable");
  AST_IDLE_NO_DRIVE: assert property (!mode_valid [*3] |-> port1_oe == 8'h00)
    else $error("drive without mode");
  AST_PROGRAM_RELEASES: assert property (vpp_high [*6] |-> port1_oe == 8'h00)
    else $error("drive while programming");
  AST_READBACK_TOP: assert property (port1_oe == 8'hc0 |-> port1_out[5:0] == 6'h00)
    else $error("readback low bits");
  AST_SEC1_STICKY: assert property (sec1_seen_reg && port1_oe == 8'hc0 |-> port1_out[7])
    else $error("bit 1 lost");
  AST_SEC2_BLOCKS: assert property (sec2_seen_reg |-> port1_oe != 8'hff)
    else $error("verify not blocked");
  AST_SETTLED: assert property (quiet_reg >= 6'h30 |-> $stable(port1_out) && $stable(port1_oe))
    else $error("late data");
  AST_ARMING_HOLDS: assert property (serial_code_in [*8] |-> !$rose(mode_valid))
    else $error("mode during arming");
  COV_MODE: cover property ($rose(mode_valid));
  COV_READBACK: cover property (port1_oe == 8'hc0 && port1_out[7]);
  COV_PULSE: cover property (vpp_high && !program_strobe_n);
endmodule : otp_prog_ctrl_properties

bind otp_prog_ctrl otp_prog_ctrl_properties chk_u (
  .mclk                (mclk),
  .rst_n               (rst_n),
  .serial_code_in      (serial_code_in),
  .program_strobe_n    (program_strobe_n),
  .vpp_high            (vpp_high),
  .address_byte_select (address_byte_select),
  .port3_in            (port3_in),
  .port1_in            (port1_in),
  .port1_out           (port1_out),
  .port1_oe            (port1_oe),
  .mode_valid          (mode_valid)
);

// >>> tb/otp_programmer_model.sv
// programmer model driving mode entry, address and strobe pins
`timescale 1ns/1ps
module otp_programmer_model (
  // clock
  input  wire logic       mclk,
  // pins toward the device
  output logic            serial_code_in,
  output logic            program_strobe_n,
  output logic            vpp_high,
  output logic            address_byte_select,
  output logic      [7:0] port3_in,
  output logic      [7:0] p1_drv
);
  // idle levels at time zero
  initial
  begin
    serial_code_in = 1'b0;
    program_strobe_n = 1'b1;
    vpp_high = 1'b0;
    address_byte_select = 1'b0;
    port3_in = 8'h00;
    p1_drv = 8'h5a;
  end
  // wait n edges, then step past the edge
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // arm with a high run, then shift the code
  task send_code(input logic [9:0] code);
    serial_code_in = 1'b1;
    tick(25); // 24 counted highs plus the edge that enters the armed state
    for (int i = 0; i < 10; i++)
    begin
      serial_code_in = code[i]; // lsb first
      tick(1);
    end
    serial_code_in = 1'b0;
  endtask : send_code
  // high bits under select, then the low byte
  task set_addr(input logic [10:0] a);
    address_byte_select = 1'b1;
    port3_in = {5'h00, a[10:8]};
    tick(13);
    address_byte_select = 1'b0;
    tick(2);
    port3_in = a[7:0];
    tick(1);
  endtask : set_addr
  // vpp, data, strobe pulses, vpp off
  task prog_byte(input logic [7:0] d);
    tick(24); // address settled before vpp
    vpp_high = 1'b1;
    tick(4);
    p1_drv = d;
    tick(38);
    repeat (25) // full pulse count, strobe left high
    begin
      program_strobe_n = 1'b0;
      tick(4);
      program_strobe_n = 1'b1;
      tick(4);
    end
    vpp_high = 1'b0;
    p1_drv = ~d; // released bus shows the inverse
  endtask : prog_byte
  // random junk on the address port, which security writes must ignore
  task scramble_port3;
    port3_in = 8'($urandom);
  endtask : scramble_port3
endmodule : otp_programmer_model

// >>> tb/eprom_program_verify_mode_control_tb_top.sv
// self-checking bench for the otp program and verify control
`timescale 1ns/1ps
module eprom_program_verify_mode_control_tb_top;
  // ****
  // signals
  // ****
  logic        mclk;
  logic        rst_n;
  logic        serial_code_in;
  logic        program_strobe_n;
  logic        vpp_high;
  logic        address_byte_select;
  logic [7:0]  port3_in;
  logic [7:0]  p1_drv;
  logic [7:0]  port1_in;
  logic [7:0]  port1_out;
  logic [7:0]  port1_oe;
  logic        mode_valid;
  logic        sample_req;
  logic [15:0] exp_q[$];
  logic [15:0] exp_v;
  logic [10:0] a0;
  logic [10:0] a1;
  logic [7:0]  d;
  logic [7:0]  k;
  int          errors;
  int          cmp_count;
  // clock and resolved port 1 level
  always #20 mclk = ~mclk;
  assign port1_in = (port1_oe & port1_out) | (~port1_oe & p1_drv);
  otp_programmer_model prog_u (
    .mclk                (mclk),
    .serial_code_in      (serial_code_in),
    .program_strobe_n    (program_strobe_n),
    .vpp_high            (vpp_high),
    .address_byte_select (address_byte_select),
    .port3_in            (port3_in),
    .p1_drv              (p1_drv)
  );
  otp_prog_ctrl dut_u (
    .mclk                (mclk),
    .rst_n               (rst_n),
    .serial_code_in      (serial_code_in),
    .program_strobe_n    (program_strobe_n),
    .vpp_high            (vpp_high),
    .address_byte_select (address_byte_select),
    .port3_in            (port3_in),
    .port1_in            (port1_in),
    .port1_out           (port1_out),
    .port1_oe            (port1_oe),
    .mode_valid          (mode_valid)
  );
  task note_err(input logic [15:0] g, input logic [15:0] e);
    errors++;
    $display("Error at %0t: got %h expected %h", $time, g, e);
  endtask : note_err
  task report_and_stop;
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // note an expectation, sample after n edges
  task check(input logic [15:0] e, input int n);
    prog_u.tick(n);
    exp_q.push_back(e);
    sample_req = 1'b1;
    prog_u.tick(1);
    sample_req = 1'b0;
  endtask : check
  // enter a known mode, bounded wait for it
  task enter(input logic [9:0] c);
    prog_u.send_code(c);
    for (int i = 0; i < 20 && mode_valid !== 1'b1; i++)
      prog_u.tick(1);
    cmp_count++;
    if (mode_valid !== 1'b1)
    begin
      note_err({15'h0000, mode_valid}, 16'h0001);
      report_and_stop();
    end
  endtask : enter
  task verify(input logic [9:0] c, input logic [10:0] a, input logic [15:0] e);
    enter(c);
    prog_u.set_addr(a);
    check(e, 48);
  endtask : verify
  // compare sampled port 1 with the oldest note
  always @(posedge mclk)
    if (sample_req === 1'b1)
    begin
      exp_v = exp_q.pop_front();
      cmp_count++;
      if ({port1_oe, port1_out & port1_oe} !== exp_v)
        note_err({port1_oe, port1_out & port1_oe}, exp_v);
    end
  // hang guard
  initial
  begin
    repeat (40000) @(posedge mclk);
    note_err(16'h0000, 16'hffff);
    report_and_stop();
  end
  // main sequence
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    sample_req = 1'b0;
    errors = 0;
    cmp_count = 0;
    void'($urandom(29));
    a0 = 11'($urandom);
    a1 = a0 ^ 11'h401;
    d = 8'($urandom) & 8'h7e;
    k = 8'($urandom) | 8'h81;
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    prog_u.tick(2);
    verify(otp_prog_pkg::CODE_USER, a0, {8'hff, otp_prog_pkg::ERASED_BYTE});
    prog_u.send_code(10'h2f0);
    prog_u.tick(16);
    cmp_count++;
    if (mode_valid !== 1'b0)
      note_err({15'h0000, mode_valid}, 16'h0000);
    prog_u.set_addr(a1);
    prog_u.prog_byte(8'h00);
    check(16'h0000, 48);
    verify(otp_prog_pkg::CODE_USER, a1, 16'hffff);
    prog_u.prog_byte(d);
    check({8'hff, d}, 48);
    enter(otp_prog_pkg::CODE_KEY);
    check(16'hffff, 14);
    prog_u.prog_byte(k);
    check({8'hff, k}, 48);
    verify(otp_prog_pkg::CODE_USER, a1, {8'hff, ~(d ^ k)});
    verify(otp_prog_pkg::CODE_SEC1, a0, 16'hc000);
    prog_u.scramble_port3();
    prog_u.prog_byte(8'($urandom));
    check(16'hc080, 48);
    enter(otp_prog_pkg::CODE_KEY);
    prog_u.prog_byte(8'h00);
    check(16'h0000, 48);
    verify(otp_prog_pkg::CODE_USER, a1, {8'hff, ~(d ^ k)});
    prog_u.prog_byte(8'h00);
    check({8'hff, ~(d ^ k)}, 48);
    enter(otp_prog_pkg::CODE_SEC2);
    prog_u.prog_byte(8'($urandom));
    enter(otp_prog_pkg::CODE_SEC1);
    check(16'hc0c0, 48);
    enter(otp_prog_pkg::CODE_USER);
    check(16'h0000, 48);
    report_and_stop();
  end
endmodule : eprom_program_verify_mode_control_tb_top
